// *** dsau_top.sv ***
// Data-space access unit: decode, byte lanes, alignment trap, working registers
// What this block does
// RL1: Separate read and write address paths, formed independently; special register port shares one address, the read's if both request.
// RL2: Effective addresses are 16-bit byte addresses over a 64 Kbyte space.
// RL3: Top address bit one routes to the program window, zero to memory.
// RL4: At most 12 Kbytes implemented; outside that reads return zero.
// RL5: Low byte at even address, high byte at the next odd address.
// RL6: Post-increment adds one for bytes, two for words.
// RL7: Byte read fetches the word, picks by bit zero, returns on low lane.
// RL8: Shared word decode with per-lane write strobes; bytes write one lane.
// RL9: Word access at an odd address raises an address error.
// RL10: Misaligned read completes; misaligned write is suppressed; trap follows.
// RL11: Byte load into a working register keeps its high byte.
// RL12: Sign-extend widens a signed byte; zero-extend clears the high byte.
// RL13: Bytes 0x0000 to 0x0FFF decode as the special register region.
// RL14: Unused special register addresses read back as zero.
// RL15: 0x0000 to 0x1FFF is the near region, reached by a 13-bit field.
// RL16: Whole space reachable by 16-bit direct or register-pointer moves.
// RL17: Address error is a one-cycle request naming read or write.
`default_nettype none
module dsau_top #(
   parameter int RAM_WORDS = 4096
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Read address path
   input  wire logic        rd_req,
   input  wire logic        rd_word,
   input  wire logic        rd_use_ptr,
   input  wire logic [15:0] rd_direct_addr,
   input  wire logic        rd_near_form,
   input  wire logic [3:0]  rd_ptr_sel,
   input  wire logic        rd_post_inc,
   input  wire logic        rd_load_en,
   input  wire logic [3:0]  rd_load_dst,
   output logic [15:0]      rd_data,
   output logic             rd_valid,
   // Write address path
   input  wire logic        wr_req,
   input  wire logic        wr_word,
   input  wire logic        wr_use_ptr,
   input  wire logic [15:0] wr_direct_addr,
   input  wire logic        wr_near_form,
   input  wire logic [3:0]  wr_ptr_sel,
   input  wire logic        wr_post_inc,
   input  wire logic [15:0] wr_data,
   // Special register port
   output logic [11:0]      sfr_addr,
   output logic             sfr_rd,
   output logic [1:0]       sfr_wr_lane,
   output logic [15:0]      sfr_wdata,
   input  wire logic [15:0] sfr_rdata,
   input  wire logic        sfr_hit,
   // Program window port
   output logic [14:0]      program_window_addr,
   output logic             program_window_rd,
   input  wire logic [15:0] program_window_data,
   // Working register operations
   input  wire logic [1:0]  ext_op,
   input  wire logic [3:0]  ext_reg,
   input  wire logic        wreg_wr_en,
   input  wire logic [3:0]  wreg_wr_sel,
   input  wire logic [15:0] wreg_wr_data,
   input  wire logic [3:0]  wreg_rd_sel,
   output logic [15:0]      wreg_rd_data,
   // Exception request
   output logic             addr_err_req,
   output logic             addr_err_is_write
);
   localparam int RAM_AW = $clog2(RAM_WORDS);

   logic [7:0]  ram_lo [RAM_WORDS];
   logic [7:0]  ram_hi [RAM_WORDS];
   logic [15:0] wreg_q [dsau_pkg::NUM_WREGS];
   logic [15:0] rd_ea;
   logic [15:0] wr_ea;
   logic [15:0] rd_word_d;
   logic [15:0] rd_data_d;
   logic [1:0]  wr_lane;
   logic        wr_ok;
   logic        rd_pend_q;
   logic        rd_sel_hi_q;
   logic        rd_word_q;
   logic [15:0] rd_raw;
   logic        err_q;
   logic        err_wr_q;
   logic [RAM_AW-1:0] rd_idx;
   logic [RAM_AW-1:0] wr_idx;
   logic [15:0] ram_word_q;
   logic [1:0]  rd_region_q;
   logic        rd_sfr_hit_q;
   logic        rd_load_q;
   logic [3:0]  rd_dst_q;
   logic [15:0] rd_raw_q;

   dsau_decode_if rd_if ();
   dsau_decode_if wr_if ();

   // Effective address forming per path; near form keeps 13 bits
   always_comb begin
      if (rd_use_ptr) begin
         rd_ea = wreg_q[rd_ptr_sel];                                   // [RL16]
      end else if (rd_near_form) begin
         rd_ea = {3'h0, rd_direct_addr[dsau_pkg::NEAR_FIELD_W-1:0]};    // [RL15]
      end else begin
         rd_ea = rd_direct_addr;                                       // [RL16] [RL2]
      end
   end

   always_comb begin
      if (wr_use_ptr) begin
         wr_ea = wreg_q[wr_ptr_sel];                                   // [RL16]
      end else if (wr_near_form) begin
         wr_ea = {3'h0, wr_direct_addr[dsau_pkg::NEAR_FIELD_W-1:0]};    // [RL15]
      end else begin
         wr_ea = wr_direct_addr;                                       // [RL16]
      end
   end

   // Two independent decoders, one per path
   assign rd_if.eff_byte_addr = rd_ea;                                 // [RL1]
   assign rd_if.is_word       = rd_word;
   assign wr_if.eff_byte_addr = wr_ea;                                 // [RL1]
   assign wr_if.is_word       = wr_word;

   dsau_addr_decode u_rd_dec (
      .p (rd_if.dec)
   );
   dsau_addr_decode u_wr_dec (
      .p (wr_if.dec)
   );

   // Word index into the RAM region
   assign rd_idx = RAM_AW'((rd_ea - dsau_pkg::RAM_FIRST) >> 1);
   assign wr_idx = RAM_AW'((wr_ea - dsau_pkg::RAM_FIRST) >> 1);

   // Write lane strobes; misaligned word write is suppressed
   assign wr_ok   = wr_req & ~wr_if.misaligned;                        // [RL10]
   always_comb begin
      if (wr_word) begin
         wr_lane = 2'h3;
      end else if (wr_ea[0]) begin
         wr_lane = 2'h2;                                               // [RL8] [RL5]
      end else begin
         wr_lane = 2'h1;                                               // [RL8] [RL5]
      end
   end

   // RAM byte lanes with shared word decode
   always_ff @(posedge mclk) begin
      if (wr_ok && wr_if.region == dsau_pkg::DSAU_REG_RAM) begin
         if (wr_lane[0]) begin
            ram_lo[wr_idx] <= wr_data[7:0];                            // [RL8]
         end
         if (wr_lane[1]) begin
            ram_hi[wr_idx] <= wr_word ? wr_data[15:8] : wr_data[7:0];  // [RL8]
         end
      end
   end

   // RAM read: whole containing word
   always_ff @(posedge mclk) begin
      ram_word_q <= {ram_hi[rd_idx], ram_lo[rd_idx]};                  // [RL7]
   end

   // Special register and window strobes
   assign sfr_addr            = rd_req ? rd_ea[11:0] : wr_ea[11:0];
   assign sfr_rd              = rd_req & (rd_if.region == dsau_pkg::DSAU_REG_SFR);
   assign sfr_wr_lane         = (wr_ok && wr_if.region == dsau_pkg::DSAU_REG_SFR)
                              ? wr_lane : 2'h0;                        // [RL8] [RL10]
   assign sfr_wdata           = wr_word ? wr_data : {wr_data[7:0], wr_data[7:0]};
   assign program_window_addr = rd_ea[14:0];
   assign program_window_rd   = rd_req & (rd_if.region == dsau_pkg::DSAU_REG_WIN); // [RL3]

   // Read pipeline capture
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_pend_q    <= 1'b0;
         rd_sel_hi_q  <= 1'b0;
         rd_word_q    <= 1'b0;
         rd_region_q  <= 2'h0;
         rd_sfr_hit_q <= 1'b0;
         rd_load_q    <= 1'b0;
         rd_dst_q     <= 4'h0;
         rd_raw_q     <= dsau_pkg::ZERO_WORD;
      end else begin
         rd_pend_q    <= rd_req;                                       // [RL10]
         rd_sel_hi_q  <= rd_ea[0];
         rd_word_q    <= rd_word;
         rd_region_q  <= rd_if.region;
         rd_sfr_hit_q <= sfr_hit;
         rd_load_q    <= rd_req & rd_load_en;
         rd_dst_q     <= rd_load_dst;
         rd_raw_q     <= (rd_if.region == dsau_pkg::DSAU_REG_WIN)
                         ? program_window_data
                         : (sfr_hit ? sfr_rdata : dsau_pkg::ZERO_WORD);
      end
   end

   // Source select with zero for unimplemented and unused locations
   always_comb begin
      rd_raw = dsau_pkg::ZERO_WORD;
      case (rd_region_q)
         dsau_pkg::DSAU_REG_RAM:  rd_raw = ram_word_q;
         dsau_pkg::DSAU_REG_SFR:  rd_raw = rd_sfr_hit_q ? rd_raw_q : dsau_pkg::ZERO_WORD; // [RL14]
         dsau_pkg::DSAU_REG_WIN:  rd_raw = rd_raw_q;
         default:                 rd_raw = dsau_pkg::ZERO_WORD;        // [RL4]
      endcase
   end
   assign rd_word_d = rd_raw;

   // Byte select onto the low lane
   always_comb begin
      if (rd_word_q) begin
         rd_data_d = rd_word_d;
      end else if (rd_sel_hi_q) begin
         rd_data_d = {8'h00, rd_word_d[15:8]};                         // [RL7] [RL5]
      end else begin
         rd_data_d = {8'h00, rd_word_d[7:0]};                          // [RL7] [RL5]
      end
   end
   assign rd_data  = rd_data_d;
   assign rd_valid = rd_pend_q;

   // Working registers: loads, extends, direct writes, pointer updates
   for (genvar g = 0; g < dsau_pkg::NUM_WREGS; g++) begin : g_wreg
      // Register number at the select width, so compares stay 4 bits wide
      localparam logic [3:0] IDX = 4'(g);
      always_ff @(posedge mclk) begin
         if (rst) begin
            wreg_q[g] <= dsau_pkg::ZERO_WORD;
         end else if (rd_load_q && rd_dst_q == IDX) begin
            if (rd_word_q) begin
               wreg_q[g] <= rd_data_d;
            end else begin
               wreg_q[g] <= {wreg_q[g][15:8], rd_data_d[7:0]};          // [RL11]
            end
         end else if (ext_op == dsau_pkg::DSAU_EXT_SIGN && ext_reg == IDX) begin
            wreg_q[g] <= {{8{wreg_q[g][7]}}, wreg_q[g][7:0]};          // [RL12]
         end else if (ext_op == dsau_pkg::DSAU_EXT_ZERO && ext_reg == IDX) begin
            wreg_q[g] <= {8'h00, wreg_q[g][7:0]};                      // [RL12]
         end else if (wreg_wr_en && wreg_wr_sel == IDX) begin
            wreg_q[g] <= wreg_wr_data;
         end else if (wr_req && wr_use_ptr && wr_post_inc && wr_ptr_sel == IDX) begin
            wreg_q[g] <= wr_if.post_inc_addr;                          // [RL6]
         end else if (rd_req && rd_use_ptr && rd_post_inc && rd_ptr_sel == IDX) begin
            wreg_q[g] <= rd_if.post_inc_addr;                          // [RL6]
         end
      end
   end
   assign wreg_rd_data = wreg_q[wreg_rd_sel];

   // Address error request, one cycle after the faulting access
   always_ff @(posedge mclk) begin
      if (rst) begin
         err_q    <= 1'b0;
         err_wr_q <= 1'b0;
      end else begin
         err_q    <= (rd_req & rd_if.misaligned) | (wr_req & wr_if.misaligned); // [RL9] [RL17]
         err_wr_q <= wr_req & wr_if.misaligned;                        // [RL17]
      end
   end
   assign addr_err_req      = err_q;
   assign addr_err_is_write = err_wr_q;

   // Misaligned accesses raise the error one cycle later
   sequence s_bad_rd;
      rd_req && rd_word && rd_ea[0] && !wr_req;
   endsequence
   sequence s_bad_wr;
      wr_req && wr_word && wr_ea[0];
   endsequence
   AST_RD_TRAP: assert property (@(posedge mclk) disable iff (rst) // [RL9]
      s_bad_rd |=> addr_err_req && !addr_err_is_write)
      else $error("misaligned read not trapped");
   AST_WR_TRAP: assert property (@(posedge mclk) disable iff (rst) // [RL17]
      s_bad_wr |=> addr_err_req && addr_err_is_write)
      else $error("misaligned write not trapped");
   AST_ERR_PULSE: assert property (@(posedge mclk) disable iff (rst) // [RL17]
      addr_err_req |-> $past(rd_req) || $past(wr_req))
      else $error("error request without access");
   AST_WR_SUPP: assert property (@(posedge mclk) disable iff (rst) // [RL10]
      s_bad_wr |-> sfr_wr_lane == 2'h0)
      else $error("misaligned write reached registers");
   AST_RD_DONE: assert property (@(posedge mclk) disable iff (rst) // [RL10]
      rd_req |=> rd_valid)
      else $error("read did not complete");
   AST_BYTE_LOW: assert property (@(posedge mclk) disable iff (rst) // [RL7]
      rd_req && !rd_word |=> rd_data[15:8] == 8'h00)
      else $error("byte read leaked onto high lane");
   AST_UNIMPL_ZERO: assert property (@(posedge mclk) disable iff (rst) // [RL4]
      rd_req && !rd_ea[15] && rd_ea > dsau_pkg::IMPL_LAST |=> rd_data == 16'h0000)
      else $error("unimplemented read not zero");
   AST_WIN_ROUTE: assert property (@(posedge mclk) disable iff (rst) // [RL3]
      rd_req && rd_ea[15] |-> program_window_rd && !sfr_rd)
      else $error("upper half not routed to window");
   AST_BYTE_LANE: assert property (@(posedge mclk) disable iff (rst) // [RL8]
      wr_req && !wr_word && wr_ea <= dsau_pkg::SFR_LAST
      |-> sfr_wr_lane == {wr_ea[0], !wr_ea[0]})
      else $error("byte write strobe on wrong lane");
   // Near form must always land inside the near region on both paths
   AST_NEAR_RD: assert property (@(posedge mclk) disable iff (rst) // [RL15]
      rd_req && rd_near_form && !rd_use_ptr |-> rd_if.in_near)
      else $error("near read outside near region");
   AST_NEAR_WR: assert property (@(posedge mclk) disable iff (rst) // [RL15]
      wr_req && wr_near_form && !wr_use_ptr |-> wr_if.in_near)
      else $error("near write outside near region");
endmodule : dsau_top
`default_nettype wire

// *** dsau_pkg.sv ***
// Package with constants and types for the data-space access unit
`default_nettype none
package dsau_pkg;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 16;
   localparam int          BYTE_W         = 8;
   localparam logic [15:0] SFR_LAST       = 16'h0FFF;
   localparam logic [15:0] NEAR_LAST      = 16'h1FFF;
   localparam logic [15:0] RAM_FIRST      = 16'h1000;
   localparam logic [15:0] IMPL_LAST      = 16'h2FFF;
   localparam int          NEAR_FIELD_W   = 13;
   localparam logic [15:0] STEP_BYTE      = 16'h0001;
   localparam logic [15:0] STEP_WORD      = 16'h0002;
   localparam logic [15:0] ZERO_WORD      = 16'h0000;
   localparam int          NUM_WREGS      = 16;
   localparam int          WREG_IDX_W     = 4;

   // Region an address falls into
   typedef enum logic [1:0] {
      DSAU_REG_SFR,
      DSAU_REG_RAM,
      DSAU_REG_NONE,
      DSAU_REG_WIN
   } dsau_region_t;

   // Extend operation applied to a working register
   typedef enum logic [1:0] {
      DSAU_EXT_NONE,
      DSAU_EXT_SIGN,
      DSAU_EXT_ZERO
   } dsau_ext_t;
endpackage : dsau_pkg
`default_nettype wire

// *** dsau_decode_if.sv ***
// Interface carrying one address path between the top and its decoder
`default_nettype none
interface dsau_decode_if;
   logic [15:0]            eff_byte_addr;
   logic                   is_word;
   dsau_pkg::dsau_region_t region;
   logic                   in_near;
   logic                   misaligned;
   logic [15:0]            post_inc_addr;
   modport top (output eff_byte_addr, output is_word,
                input region, input in_near, input misaligned, input post_inc_addr);
   modport dec (input eff_byte_addr, input is_word,
                output region, output in_near, output misaligned, output post_inc_addr);
endinterface : dsau_decode_if
`default_nettype wire

// *** dsau_addr_decode.sv ***
// Address decoder for one address generation path
`default_nettype none
module dsau_addr_decode (
   dsau_decode_if.dec p
);
   // Region decode by address bits
   always_comb begin
      if (p.eff_byte_addr[15]) begin
         p.region = dsau_pkg::DSAU_REG_WIN;                     // [RL3]
      end else if (p.eff_byte_addr <= dsau_pkg::SFR_LAST) begin
         p.region = dsau_pkg::DSAU_REG_SFR;                     // [RL13]
      end else if (p.eff_byte_addr <= dsau_pkg::IMPL_LAST) begin
         p.region = dsau_pkg::DSAU_REG_RAM;                     // [RL4]
      end else begin
         p.region = dsau_pkg::DSAU_REG_NONE;                    // [RL4]
      end
   end

   // Near region and alignment checks
   assign p.in_near       = (p.eff_byte_addr <= dsau_pkg::NEAR_LAST);          // [RL15]
   assign p.misaligned    = p.is_word & p.eff_byte_addr[0];                    // [RL9]
   assign p.post_inc_addr = p.eff_byte_addr
                          + (p.is_word ? dsau_pkg::STEP_WORD : dsau_pkg::STEP_BYTE); // [RL6]
endmodule : dsau_addr_decode
`default_nettype wire

// *** dsau_far_model.sv ***
// Far-side model answering the special register region and the program window
`default_nettype none
module dsau_far_model (
   // Clock
   input  wire logic        mclk,
   // Special register region
   input  wire logic [11:0] sfr_addr,
   input  wire logic        sfr_rd,
   output logic [15:0]      sfr_rdata,
   output logic             sfr_hit,
   // Program window
   input  wire logic [14:0] program_window_addr,
   input  wire logic        program_window_rd,
   output logic [15:0]      program_window_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] idle_q = 16'h0000;
   // Changing pattern shown whenever nothing is selected
   always @(posedge mclk) idle_q <= idle_q + 16'h1357;
   // Only the lowest 64 bytes answer; the rest is unused space
   assign sfr_hit   = sfr_rd && (sfr_addr < 12'h040);
   assign sfr_rdata = sfr_hit ? {4'hC, sfr_addr} : ~idle_q;
   // Window data is a fixed function of the window address
   assign program_window_data = program_window_rd ?
                                ({1'b1, program_window_addr} ^ 16'h0F0F) : idle_q;
endmodule : dsau_far_model
`default_nettype wire

// *** dsau_top_tb.sv ***
// Self-checking testbench for the data-space access unit
`default_nettype none
module dsau_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst = 1'b1;
   logic rd_req, rd_word, rd_use_ptr, rd_near_form, rd_post_inc, rd_load_en;
   logic wr_req, wr_word, wr_use_ptr, wr_near_form, wr_post_inc, wreg_wr_en;
   logic [3:0] rd_ptr_sel, rd_load_dst, wr_ptr_sel, ext_reg, wreg_wr_sel, wreg_rd_sel;
   logic [15:0] rd_direct_addr, wr_direct_addr, wr_data, wreg_wr_data, sfr_rdata;
   logic [15:0] rd_data, sfr_wdata, program_window_data, wreg_rd_data, lfsr_q, a, d, wd_s;
   logic [11:0] sfr_addr;
   logic [14:0] program_window_addr, pw_addr_s;
   logic [1:0] ext_op, sfr_wr_lane, lane_s;
   logic rd_valid, sfr_hit, sfr_rd, program_window_rd, addr_err_req, addr_err_is_write, pw_s;
   int error_cnt = 0, comparisons = 0;
   // Clock at 50 MHz
   always #10 mclk = ~mclk;
   dsau_top i_dsau_top (.mclk(mclk), .rst(rst), .rd_req(rd_req), .rd_word(rd_word),
      .rd_use_ptr(rd_use_ptr), .rd_direct_addr(rd_direct_addr), .rd_near_form(rd_near_form),
      .rd_ptr_sel(rd_ptr_sel), .rd_post_inc(rd_post_inc), .rd_load_en(rd_load_en),
      .rd_load_dst(rd_load_dst), .rd_data(rd_data), .rd_valid(rd_valid), .wr_req(wr_req),
      .wr_word(wr_word), .wr_use_ptr(wr_use_ptr), .wr_direct_addr(wr_direct_addr),
      .wr_near_form(wr_near_form), .wr_ptr_sel(wr_ptr_sel), .wr_post_inc(wr_post_inc),
      .wr_data(wr_data), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr_lane(sfr_wr_lane),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .program_window_addr(program_window_addr), .program_window_rd(program_window_rd),
      .program_window_data(program_window_data), .ext_op(ext_op), .ext_reg(ext_reg),
      .wreg_wr_en(wreg_wr_en), .wreg_wr_sel(wreg_wr_sel), .wreg_wr_data(wreg_wr_data),
      .wreg_rd_sel(wreg_rd_sel), .wreg_rd_data(wreg_rd_data), .addr_err_req(addr_err_req),
      .addr_err_is_write(addr_err_is_write));
   dsau_far_model i_dsau_far_model (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .program_window_addr(program_window_addr),
      .program_window_rd(program_window_rd), .program_window_data(program_window_data));
   // Pseudo-random source, seeded at 64
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Byte picked from a word by address bit zero, on the low lane
   function automatic logic [15:0] lane(input logic [15:0] w, input logic odd);
      return odd ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
   endfunction : lane
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   // One access cycle; the answer is settled after the taking edge
   task automatic op(input logic r, input logic w, input logic wd, input logic [15:0] ra,
                     input logic [15:0] wa, input logic [15:0] dat);
      @(posedge mclk);
      rd_req <= r; wr_req <= w; rd_word <= wd; wr_word <= wd;
      rd_direct_addr <= ra; wr_direct_addr <= wa; wr_data <= dat;
      #1;
      pw_s = program_window_rd; pw_addr_s = program_window_addr; lane_s = sfr_wr_lane;
      wd_s = sfr_wdata;
      @(posedge mclk);
      rd_req <= 1'b0; wr_req <= 1'b0; rd_load_en <= 1'b0; ext_op <= 2'h0;
      #1;
   endtask : op
   task automatic setw(input logic [3:0] s, input logic [15:0] v);
      @(posedge mclk);
      wreg_wr_en <= 1'b1; wreg_wr_sel <= s; wreg_wr_data <= v; wreg_rd_sel <= s;
      @(posedge mclk);
      wreg_wr_en <= 1'b0;
   endtask : setw
   task automatic wr_chk(input string n, input logic [3:0] s, input logic [15:0] exp);
      @(posedge mclk);
      wreg_rd_sel <= s;
      #1;
      chk(n, wreg_rd_data, exp);
   endtask : wr_chk
   // Watchdog bounding the whole run
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      {rd_req, rd_word, rd_use_ptr, rd_near_form, rd_post_inc, rd_load_en} = '0;
      {wr_req, wr_word, wr_use_ptr, wr_near_form, wr_post_inc, wreg_wr_en} = '0;
      {rd_ptr_sel, rd_load_dst, wr_ptr_sel, ext_reg, wreg_wr_sel, wreg_rd_sel} = '0;
      {rd_direct_addr, wr_direct_addr, wr_data, wreg_wr_data, ext_op} = '0;
      lfsr_q = 16'h0040;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("valid_rst", {15'h0, rd_valid}, 16'h0000);
      chk("err_rst", {15'h0, addr_err_req}, 16'h0000);
      for (int i = 0; i < 16; i++) wr_chk("wreg_rst", i[3:0], 16'h0000);
      // Random word/byte traffic in implemented memory, with alignment faults
      for (int k = 0; k < 12; k++) begin
         lfsr_q = lfsr(lfsr_q); a = 16'h1000 + (lfsr_q & 16'h1FFE);
         lfsr_q = lfsr(lfsr_q); d = lfsr_q;
         op(0, 1, 1, 0, a, d);
         op(1, 0, 1, a, 0, 0);
         chk("word", rd_data, d);
         chk("pw_idle", {15'h0, pw_s}, 16'h0000);
         op(1, 0, 0, a, 0, 0);
         chk("lo_byte", rd_data, lane(d, 1'b0));
         op(1, 0, 0, a + 16'h1, 0, 0);
         chk("hi_byte", rd_data, lane(d, 1'b1));
         op(0, 1, 0, 0, a + 16'h1, {8'hFF, ~d[7:0]});
         op(1, 0, 1, a, 0, 0);
         chk("lane_wr", rd_data, {~d[7:0], d[7:0]});
         d = {~d[7:0], d[7:0]};
         op(0, 1, 1, 0, a + 16'h1, ~d);
         chk("err_w", {14'h0, addr_err_req, addr_err_is_write}, 16'h0003);
         @(posedge mclk);
         #1;
         chk("err_pulse", {15'h0, addr_err_req}, 16'h0000);
         op(1, 0, 1, a, 0, 0);
         chk("wr_supp", rd_data, d);
         op(1, 0, 1, a + 16'h1, 0, 0);
         chk("err_r", {13'h0, rd_valid, addr_err_req, addr_err_is_write}, 16'h0006);
      end
      // Unimplemented memory, special registers and program window
      op(0, 1, 1, 0, 16'h3000, 16'hFFFF);
      op(1, 0, 1, 16'h3000, 0, 0);
      chk("unimpl", rd_data, 16'h0000);
      op(1, 0, 1, 16'h0020, 0, 0);
      chk("sfr_hit", rd_data, 16'hC020);
      op(1, 0, 1, 16'h0800, 0, 0);
      chk("sfr_unused", rd_data, 16'h0000);
      op(0, 1, 0, 0, 16'h0021, 16'h0055);
      chk("sfr_lane", {14'h0, lane_s}, 16'h0002);
      chk("sfr_wdata", wd_s, 16'h5555);
      op(0, 1, 1, 0, 16'h0023, 16'hAAAA);
      chk("sfr_supp", {14'h0, lane_s}, 16'h0000);
      op(1, 0, 1, 16'hC468, 0, 0);
      chk("pw_rd", {15'h0, pw_s}, 16'h0001);
      chk("pw_addr", {1'h0, pw_addr_s}, 16'h4468);
      chk("pw_data", rd_data, 16'hCB67);
      // Simultaneous read and write on separate paths, then near form
      op(0, 1, 1, 0, 16'h1000, 16'hBEEF);
      op(1, 1, 1, 16'h1000, 16'h1002, 16'h4321);
      chk("dual_rd", rd_data, 16'hBEEF);
      rd_near_form <= 1'b1;
      wr_near_form <= 1'b1;
      op(1, 1, 1, 16'hF002, 16'hF006, 16'h5A5A);
      chk("near", rd_data, 16'h4321);
      rd_near_form <= 1'b0;
      wr_near_form <= 1'b0;
      op(1, 0, 1, 16'h1006, 0, 0);
      chk("near_wr", rd_data, 16'h5A5A);
      // Pointer reads and writes with post-increment
      setw(4'h3, 16'h1000);
      rd_use_ptr <= 1'b1; rd_ptr_sel <= 4'h3; rd_post_inc <= 1'b1;
      op(1, 0, 1, 0, 0, 0);
      chk("ptr_rd", rd_data, 16'hBEEF);
      wr_chk("inc_word", 4'h3, 16'h1002);
      op(1, 0, 0, 0, 0, 0);
      chk("ptr_byte", rd_data, 16'h0021);
      wr_chk("inc_byte", 4'h3, 16'h1003);
      rd_use_ptr <= 1'b0; rd_post_inc <= 1'b0;
      setw(4'h4, 16'h1004);
      wr_use_ptr <= 1'b1; wr_ptr_sel <= 4'h4; wr_post_inc <= 1'b1;
      op(0, 1, 1, 0, 0, 16'h1234);
      wr_use_ptr <= 1'b0; wr_post_inc <= 1'b0;
      wr_chk("inc_wr", 4'h4, 16'h1006);
      op(1, 0, 1, 16'h1004, 0, 0);
      chk("ptr_wr", rd_data, 16'h1234);
      // Byte load keeps the high byte; sign and zero extension
      setw(4'h5, 16'h7700);
      rd_load_en <= 1'b1; rd_load_dst <= 4'h5;
      op(1, 0, 0, 16'h1000, 0, 0);
      wr_chk("load", 4'h5, 16'h77EF);
      ext_op <= dsau_pkg::DSAU_EXT_SIGN; ext_reg <= 4'h5;
      @(posedge mclk);
      ext_op <= dsau_pkg::DSAU_EXT_NONE;
      wr_chk("sext", 4'h5, 16'hFFEF);
      ext_op <= dsau_pkg::DSAU_EXT_ZERO;
      @(posedge mclk);
      ext_op <= dsau_pkg::DSAU_EXT_NONE;
      wr_chk("zext", 4'h5, 16'h00EF);
      end_of_test();
   end
endmodule : dsau_top_tb
`default_nettype wire
